// ===== bench/pwrcs_regs_chk.sv
// Port-level assertions for the power control and status registers
`timescale 1ns/1ns
module pwrcs_regs_chk (
  input wire clk,
  input wire reset,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire supply_low_cmp_in,
  input wire core_deep_sleep_bit,
  input wire [2:0] threshold_level_select,
  input wire supply_monitor_enable,
  input wire standby_select,
  input wire deep_sleep_standby,
  input wire ext_irq_line8
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire [4:0] ctl = {threshold_level_select, supply_monitor_enable,
    standby_select};
  // Input held three cycles so the sync delay is judged exactly
  a_flag_tracks: assert property (
    supply_monitor_enable && $past(supply_monitor_enable) &&
    $past(supply_monitor_enable, 2) && $past(supply_monitor_enable, 3) &&
    $past(supply_monitor_enable, 4) &&
    $past(supply_low_cmp_in, 2) == $past(supply_low_cmp_in, 3) &&
    $past(supply_low_cmp_in, 3) == $past(supply_low_cmp_in, 4)
    |-> ext_irq_line8 == $past(supply_low_cmp_in, 3))
    else $error("flag does not follow comparator");
  a_flag_disabled: assert property (
    !supply_monitor_enable && !$past(supply_monitor_enable)
    |-> !ext_irq_line8) else $error("flag set while monitor off");
  a_standby_path: assert property (
    deep_sleep_standby == (core_deep_sleep_bit && standby_select))
    else $error("standby request wrong");
  a_ctrl_steady: assert property (
    !$rose(s_axi_bvalid) |-> $stable(ctl))
    else $error("control changed without a write");
  a_reset_zero: assert property (
    $past(reset) |-> ctl == 5'h00 && !ext_irq_line8)
    else $error("fields not zero after reset");
  a_wr_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
endmodule // pwrcs_regs_chk

bind pwrcs_regs pwrcs_regs_chk u_chk (.*);

// ===== bench/tb_power_control_status_regs.sv
// Self-checking bench for the power control and status registers
`timescale 1ns/1ns
module tb_power_control_status_regs;
  logic clk = 0, reset = 1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic supply_low_cmp_in = 0, core_deep_sleep_bit = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, supply_monitor_enable, standby_select;
  logic deep_sleep_standby, ext_irq_line8, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] threshold_level_select;
  int failures = 0, checks_done = 0;
  pwrcs_regs u_dut (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Ready only moves on clock edges, so mid-cycle sampling is safe
  task automatic wr(input [11:0] a, input [31:0] d, input [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    tb = 0;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    chk(r, er);
  endtask
  task automatic rd(input [11:0] a, input [31:0] ed, input [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    tr = 0;
    while (!tr) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    chk(d, ed);
    chk(r, er);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    rd(12'h000, '0, 2'h0);
    rd(12'h004, '0, 2'h0);
    wr(12'h000, 32'hffff_ffff, 2'h0);
    rd(12'h000, 32'h0000_00f2, 2'h0);
    chk(supply_monitor_enable, 1);
    chk(standby_select, 1);
    for (int i = 0; i < 8; i++) begin
      wr(12'h000, {i[2:0], 5'h10}, 2'h0);
      rd(12'h000, {i[2:0], 5'h10}, 2'h0);
      chk(threshold_level_select, i);
    end
    wr(12'h000, 32'h0000_0002, 2'h0);
    @(posedge clk) core_deep_sleep_bit <= 1;
    @(negedge clk) chk(deep_sleep_standby, 1);
    wr(12'h000, '0, 2'h0);
    @(negedge clk) chk(deep_sleep_standby, 0);
    wr(12'h000, 32'h0000_0010, 2'h0);
    @(posedge clk) supply_low_cmp_in <= 1;
    repeat (6) @(posedge clk);
    rd(12'h004, 32'h0000_0004, 2'h0);
    chk(ext_irq_line8, 1);
    supply_low_cmp_in <= 0;
    repeat (6) @(posedge clk);
    rd(12'h004, '0, 2'h0);
    chk(ext_irq_line8, 0);
    // A fall and a rise of the flag both leave sticky events behind
    rd(12'h020, 32'h0000_0003, 2'h0);
    supply_low_cmp_in <= 1;
    repeat (6) @(posedge clk);
    wr(12'h000, '0, 2'h0);
    rd(12'h004, '0, 2'h0);
    chk(ext_irq_line8, 0);
    // Low supply at enable time must still raise a below event
    wr(12'h028, 32'h0000_0003, 2'h0);
    rd(12'h020, '0, 2'h0);
    wr(12'h000, 32'h0000_0010, 2'h0);
    repeat (6) @(posedge clk);
    rd(12'h020, 32'h0000_0001, 2'h0);
    chk(irq, 0);
    wr(12'h024, 32'h0000_0001, 2'h0);
    @(negedge clk) chk(irq, 1);
    rd(12'h024, 32'h0000_0001, 2'h0);
    rd(12'h028, '0, 2'h0);
    wr(12'h028, 32'h0000_0001, 2'h0);
    @(negedge clk) chk(irq, 0);
    rd(12'h020, '0, 2'h0);
    wr(12'h004, 32'hffff_ffff, 2'h0);
    rd(12'h004, 32'h0000_0004, 2'h0);
    wr(12'h100, 32'hffff_ffff, 2'h2);
    rd(12'h100, '0, 2'h2);
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule // tb_power_control_status_regs

// ===== src/pwrcs_defs.vh
// Register map, field positions and reset values of the power registers
`ifndef PWRCS_DEFS_VH
`define PWRCS_DEFS_VH

`define PWRCS_ADDR_W 12
`define PWRCS_OFF_CONTROL 12'h000
`define PWRCS_OFF_STATUS 12'h004
`define PWRCS_OFF_EVT_STATUS 12'h020
`define PWRCS_OFF_EVT_ENABLE 12'h024
`define PWRCS_OFF_EVT_CLEAR 12'h028

`define PWRCS_CTL_TLS_HI 7
`define PWRCS_CTL_TLS_LO 5
`define PWRCS_CTL_SME_BIT 4
`define PWRCS_CTL_SSEL_BIT 1
`define PWRCS_STS_FLAG_BIT 2

`define PWRCS_EVT_W 2
`define PWRCS_EVT_BELOW_BIT 0
`define PWRCS_EVT_ABOVE_BIT 1

`define PWRCS_RST_TLS 3'h0
`define PWRCS_RST_BIT 1'b0
`define PWRCS_RST_EVT 2'h0
`define PWRCS_ZERO_WORD 32'h0000_0000

`define PWRCS_RESP_OKAY 2'h0
`define PWRCS_RESP_SLVERR 2'h2

`define PWRCS_SYNC_STAGES 2

`endif

// ===== src/pwrcs_placeholder_none.v
// Intentionally empty module set not used
`timescale 1ns/1ns

// ===== src/pwrcs_regs.v
// Power control and status registers behind an AXI4-Lite slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "pwrcs_defs.vh"

// Functional notes
// - Control bits seven to five hold a three-bit monitor threshold code.
// - Control bit four switches the supply monitor on when one, off at zero.
// - Control bit one picks Standby (one) or Sleep (zero) on deep sleep.
// - Status bit two is a hardware flag, one while supply is below level.
// - The flag has meaning only while the monitor is enabled.
// - The monitor comparison output drives interrupt controller line 8.
module pwrcs_regs (
  input wire clk,
  input wire reset,
  input wire [`PWRCS_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`PWRCS_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire supply_low_cmp_in,
  input wire core_deep_sleep_bit,
  output wire [2:0] threshold_level_select,
  output wire supply_monitor_enable,
  output wire standby_select,
  output wire deep_sleep_standby,
  output wire ext_irq_line8,
  output wire irq
);
  localparam W_IDLE = 4'b0001;
  localparam W_HAVE_A = 4'b0010;
  localparam W_HAVE_D = 4'b0100;
  localparam W_RESP = 4'b1000;
  localparam R_IDLE = 2'b01;
  localparam R_RESP = 2'b10;

  // Word-aligned match; low two address bits are ignored
  function addr_is;
    input [`PWRCS_ADDR_W-1:0] addr;
    input [`PWRCS_ADDR_W-1:0] off;
    begin
      addr_is = (addr[`PWRCS_ADDR_W-1:2] == off[`PWRCS_ADDR_W-1:2]);
    end
  endfunction

  function addr_mapped;
    input [`PWRCS_ADDR_W-1:0] addr;
    begin
      addr_mapped = addr_is(addr, `PWRCS_OFF_CONTROL) |
        addr_is(addr, `PWRCS_OFF_STATUS) |
        addr_is(addr, `PWRCS_OFF_EVT_STATUS) |
        addr_is(addr, `PWRCS_OFF_EVT_ENABLE) |
        addr_is(addr, `PWRCS_OFF_EVT_CLEAR);
    end
  endfunction

  reg [3:0] wstate_reg;
  reg [3:0] wstate_next;
  reg [`PWRCS_ADDR_W-1:0] awaddr_reg;
  reg [`PWRCS_ADDR_W-1:0] awaddr_next;
  reg [31:0] wdata_reg;
  reg [31:0] wdata_next;
  reg [3:0] wstrb_reg;
  reg [3:0] wstrb_next;
  reg [1:0] bresp_reg;
  reg [1:0] bresp_next;
  reg wr_fire;

  reg [1:0] rstate_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  reg [2:0] tls_reg;
  reg sme_reg;
  reg ssel_reg;
  reg [`PWRCS_EVT_W-1:0] evt_en_reg;
  reg flag_reg;
  reg flag_prev_reg;
  reg irq_reg;

  wire cmp_sync;
  wire [`PWRCS_EVT_W-1:0] evt_status;
  wire [`PWRCS_EVT_W-1:0] evt_set;
  wire [`PWRCS_EVT_W-1:0] evt_clr;
  wire wr_lane0;
  wire [31:0] ctl_word;
  wire [31:0] sts_word;
  wire [31:0] evt_status_word;
  wire [31:0] evt_en_word;
  reg [31:0] rd_word;

  // Write channel: address and data taken in either order
  assign s_axi_awready = wstate_reg[0] | wstate_reg[2];
  assign s_axi_wready = wstate_reg[0] | wstate_reg[1];
  assign s_axi_bvalid = wstate_reg[3];
  assign s_axi_bresp = bresp_reg;

  always @* begin
    wstate_next = wstate_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    wr_fire = 1'b0;
    case (wstate_reg)
      W_IDLE: begin
        if (s_axi_awvalid) begin
          awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid) begin
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
        end
        if (s_axi_awvalid & s_axi_wvalid) begin
          wr_fire = 1'b1;
          wstate_next = W_RESP;
        end else if (s_axi_awvalid) begin
          wstate_next = W_HAVE_A;
        end else if (s_axi_wvalid) begin
          wstate_next = W_HAVE_D;
        end
      end
      W_HAVE_A: begin
        if (s_axi_wvalid) begin
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
          wr_fire = 1'b1;
          wstate_next = W_RESP;
        end
      end
      W_HAVE_D: begin
        if (s_axi_awvalid) begin
          awaddr_next = s_axi_awaddr;
          wr_fire = 1'b1;
          wstate_next = W_RESP;
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          wstate_next = W_IDLE;
        end
      end
      default: begin
        wstate_next = W_IDLE;
      end
    endcase
    if (wr_fire) begin
      bresp_next = addr_mapped(awaddr_next) ? `PWRCS_RESP_OKAY :
        `PWRCS_RESP_SLVERR;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wstate_reg <= W_IDLE;
      awaddr_reg <= {`PWRCS_ADDR_W{1'b0}};
      wdata_reg <= `PWRCS_ZERO_WORD;
      wstrb_reg <= 4'h0;
      bresp_reg <= `PWRCS_RESP_OKAY;
    end else begin
      wstate_reg <= wstate_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
    end
  end

  // Every field lives in byte lane 0, so only that strobe matters
  assign wr_lane0 = wr_fire & wstrb_next[0];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tls_reg <= `PWRCS_RST_TLS;
      sme_reg <= `PWRCS_RST_BIT;
      ssel_reg <= `PWRCS_RST_BIT;
      evt_en_reg <= `PWRCS_RST_EVT;
    end else if (wr_lane0) begin
      if (addr_is(awaddr_next, `PWRCS_OFF_CONTROL)) begin
        tls_reg <= wdata_next[`PWRCS_CTL_TLS_HI:`PWRCS_CTL_TLS_LO];
        sme_reg <= wdata_next[`PWRCS_CTL_SME_BIT];
        ssel_reg <= wdata_next[`PWRCS_CTL_SSEL_BIT];
      end
      if (addr_is(awaddr_next, `PWRCS_OFF_EVT_ENABLE)) begin
        evt_en_reg <= wdata_next[`PWRCS_EVT_W-1:0];
      end
    end
  end

  // Comparator is analog and asynchronous to clk
  pwrcs_sync #(
    .WIDTH(1)
  ) u_cmp_sync (
    .clk(clk),
    .reset(reset),
    .async_in(supply_low_cmp_in),
    .sync_out(cmp_sync)
  );

  // Flag forced low while disabled so stale comparator state never shows
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_reg <= 1'b0;
      flag_prev_reg <= 1'b0;
    end else begin
      flag_reg <= sme_reg & cmp_sync;
      flag_prev_reg <= flag_reg;
    end
  end

  // Crossings in either direction are events; enabling while low counts
  assign evt_set[`PWRCS_EVT_BELOW_BIT] = flag_reg & ~flag_prev_reg;
  assign evt_set[`PWRCS_EVT_ABOVE_BIT] = ~flag_reg & flag_prev_reg & sme_reg;
  assign evt_clr = (wr_lane0 & addr_is(awaddr_next, `PWRCS_OFF_EVT_CLEAR)) ?
    wdata_next[`PWRCS_EVT_W-1:0] : {`PWRCS_EVT_W{1'b0}};

  pwrcs_sticky #(
    .WIDTH(`PWRCS_EVT_W)
  ) u_evt (
    .clk(clk),
    .reset(reset),
    .set_in(evt_set),
    .clr_in(evt_clr),
    .bits_out(evt_status)
  );

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_status & evt_en_reg);
    end
  end

  // Read words; reserved positions are constant zero
  assign ctl_word = {24'h00_0000, tls_reg, sme_reg, 2'b00, ssel_reg,
    1'b0};
  assign sts_word = {29'h0000_0000, flag_reg, 2'b00};
  assign evt_status_word = {30'h0000_0000, evt_status};
  assign evt_en_word = {30'h0000_0000, evt_en_reg};

  always @* begin
    rd_word = `PWRCS_ZERO_WORD;
    if (addr_is(s_axi_araddr, `PWRCS_OFF_CONTROL)) begin
      rd_word = ctl_word;
    end else if (addr_is(s_axi_araddr, `PWRCS_OFF_STATUS)) begin
      rd_word = sts_word;
    end else if (addr_is(s_axi_araddr, `PWRCS_OFF_EVT_STATUS)) begin
      rd_word = evt_status_word;
    end else if (addr_is(s_axi_araddr, `PWRCS_OFF_EVT_ENABLE)) begin
      rd_word = evt_en_word;
    end
  end

  // Read channel: one outstanding read, data registered
  assign s_axi_arready = rstate_reg[0];
  assign s_axi_rvalid = rstate_reg[1];
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rstate_reg <= R_IDLE;
      rdata_reg <= `PWRCS_ZERO_WORD;
      rresp_reg <= `PWRCS_RESP_OKAY;
    end else begin
      case (rstate_reg)
        R_IDLE: begin
          if (s_axi_arvalid) begin
            rdata_reg <= rd_word;
            rresp_reg <= addr_mapped(s_axi_araddr) ? `PWRCS_RESP_OKAY :
              `PWRCS_RESP_SLVERR;
            rstate_reg <= R_RESP;
          end
        end
        R_RESP: begin
          if (s_axi_rready) begin
            rstate_reg <= R_IDLE;
          end
        end
        default: begin
          rstate_reg <= R_IDLE;
        end
      endcase
    end
  end

  assign threshold_level_select = tls_reg;
  assign supply_monitor_enable = sme_reg;
  assign standby_select = ssel_reg;
  // Standby only when the core requests deep sleep as well
  assign deep_sleep_standby = core_deep_sleep_bit & ssel_reg;
  assign ext_irq_line8 = flag_reg;
  assign irq = irq_reg;
endmodule // pwrcs_regs

// ===== src/pwrcs_sticky.v
// Bank of sticky event bits, set wins over clear
`timescale 1ns/1ns
module pwrcs_sticky #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] set_in,
  input wire [WIDTH-1:0] clr_in,
  output wire [WIDTH-1:0] bits_out
);
  reg [WIDTH-1:0] bits_reg;
  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // An event in the clearing cycle must not be lost
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          bits_reg[i] <= 1'b0;
        end else if (set_in[i]) begin
          bits_reg[i] <= 1'b1;
        end else if (clr_in[i]) begin
          bits_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign bits_out = bits_reg;
endmodule // pwrcs_sticky

// ===== src/pwrcs_sync.v
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module pwrcs_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage is read only by the second stage
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // pwrcs_sync
